// *** verilog/aic_pkg.sv ***
package aic_pkg;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS      = 10;
	localparam int GEN_PERIOD_NS      = 1_000_000;
	localparam int SPD_PERIOD_NS      = 125_000;
	localparam int TRQ_FAST_PERIOD_NS = 62_500;
	localparam int GEN_CYCLES         = GEN_PERIOD_NS / CLK_PERIOD_NS;
	localparam int SPD_CYCLES         = SPD_PERIOD_NS / CLK_PERIOD_NS;
	localparam int TRQ_FAST_CYCLES    = TRQ_FAST_PERIOD_NS / CLK_PERIOD_NS;
	localparam int FILT_FRAC          = 6;

	// ----------------------------------------------------------------
	// Register map and fields
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_CFG_FIRST  = 8'h00;
	localparam logic [7:0] REG_CFG_SECOND = 8'h04;
	localparam logic [7:0] REG_TORQUE_FB  = 8'h08;
	localparam logic [7:0] REG_SEQ_CTRL   = 8'h0c;
	localparam logic [7:0] REG_DIN_SEL    = 8'h10;
	localparam logic [7:0] REG_SEQ_VARS   = 8'h14;
	localparam logic [7:0] REG_STATUS     = 8'h18;
	localparam logic [7:0] REG_REFS       = 8'h1c;
	localparam int CFG_FUNC_LSB   = 0;
	localparam int CFG_DZ_LSB     = 8;
	localparam int CFG_FILT_LSB   = 16;
	localparam int FB_PCT_LSB     = 0;
	localparam int FB_EN_BIT      = 8;
	localparam int CTRL_SF_EN_BIT = 0;
	localparam int CTRL_SW16_BIT  = 1;

	// ----------------------------------------------------------------
	// Function codes and limits
	// ----------------------------------------------------------------
	localparam logic [5:0] FN_OFF         = 6'h00;
	localparam logic [5:0] FN_DIG_FIRST   = 6'h01;
	localparam logic [5:0] FN_DIG_LAST    = 6'h1d;
	localparam logic [5:0] FN_GENERAL     = 6'h2d;
	localparam logic [5:0] FN_SPEED       = 6'h2e;
	localparam logic [5:0] FN_UNUSED47    = 6'h2f;
	localparam logic [5:0] FN_TSCALE      = 6'h30;
	localparam logic [5:0] FN_SEQ1        = 6'h31;
	localparam logic [5:0] FN_SEQ2        = 6'h32;
	localparam logic [5:0] FN_FAST_TORQUE = 6'h33;
	localparam logic [6:0] DZ_MAX         = 7'h5a;
	localparam logic [2:0] FILT_MAX       = 3'h6;
	localparam logic [6:0] PCT_FULL       = 7'h64;
	localparam logic [7:0] OVR_NEUTRAL    = 8'h64;
	localparam logic [7:0] OVR_GAIN       = 8'h97;
	localparam logic [6:0] TRQ_GAIN       = 7'h65;
	localparam logic [5:0] DZ_GAIN        = 6'h29;
	localparam int         DZ_SHIFT_FIRST  = 1;
	localparam int         DZ_SHIFT_SECOND = 2;
	localparam logic signed [11:0] DIG_THR_FIRST  = 12'sh400;
	localparam logic signed [11:0] DIG_THR_SECOND = 12'sh200;

	// ----------------------------------------------------------------
	// Types and reset values
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [2:0] filt;
		logic [6:0] dz;
		logic [5:0] func;
	} aic_cfg_t;
	typedef logic [4:0][5:0] aic_din_sel_t;

	localparam aic_cfg_t     CFG_FIRST_RST  = {3'h0, 7'h00, FN_GENERAL};
	localparam aic_cfg_t     CFG_SECOND_RST = {3'h0, 7'h00, FN_OFF};
	localparam aic_din_sel_t DIN_SEL_RST    = {6'h00, 6'h00, 6'h00, 6'h00, 6'h01};
endpackage

// *** verilog/aic_tick.sv ***
module aic_tick #(
	parameter int unsigned DIV = 1000
) (
	input  wire logic clk_i,
	input  wire logic rst_i,
	output logic      tick_o
);
	typedef struct packed {
		logic [16:0] cnt;
		logic        tick;
	} aic_tick_state_t;

	localparam logic [16:0] LAST = 17'(DIV - 1);

	aic_tick_state_t st;
	aic_tick_state_t next_st;

	always_comb begin
		next_st      = st;
		next_st.tick = (st.cnt == LAST);
		next_st.cnt  = next_st.tick ? 17'h00000 : 17'(st.cnt + 17'h00001);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign tick_o = st.tick;

	tick_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
		tick_o |=> !tick_o) else $error("tick longer than one cycle");
endmodule // aic_tick

// *** verilog/aic_chan.sv ***
module aic_chan (
	input  wire logic               clk_i,
	input  wire logic               rst_i,
	input  wire logic               tick_i,
	input  wire logic               bypass_i,
	input  wire logic [2:0]         filt_i,
	input  wire logic [11:0]        thr_i,
	input  wire logic signed [11:0] smp_i,
	output logic signed [11:0]      y_o
);
	typedef struct packed {
		logic signed [17:0] acc;
		logic signed [11:0] y;
	} aic_chan_state_t;

	aic_chan_state_t    st;
	aic_chan_state_t    next_st;
	logic [12:0]        mag;
	logic signed [11:0] dz_val;
	logic signed [18:0] diff;

	always_comb begin
		next_st = st;
		mag     = smp_i[11] ? 13'(-{smp_i[11], smp_i}) : {1'b0, smp_i};
		// Dead band around zero
		dz_val  = (mag < {1'b0, thr_i}) ? 12'sh000 : smp_i;
		diff    = 19'($signed({dz_val, 6'h00})) - 19'(st.acc);
		if (bypass_i) begin
			next_st.acc = $signed({smp_i, 6'h00});
			next_st.y   = smp_i;
		end else if (tick_i) begin
			// Shift by the setting gives tau of 2^k steps
			if (filt_i == 3'h0) begin
				next_st.acc = $signed({dz_val, 6'h00});
			end else begin
				next_st.acc = 18'(19'(st.acc) + (diff >>> filt_i));
			end
			next_st.y = next_st.acc[17:aic_pkg::FILT_FRAC];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign y_o = st.y;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	dead_zone_a: assert property (
		tick_i && !bypass_i && (mag < {1'b0, thr_i}) && filt_i == 3'h0 |=> y_o == 12'sh000)
		else $error("dead zone not applied");
	filter_off_a: assert property (
		tick_i && !bypass_i && filt_i == 3'h0 |=> y_o == $past(dz_val))
		else $error("unfiltered path wrong");
	filter_hold_a: assert property (
		!bypass_i && !tick_i |=> $stable(y_o))
		else $error("filter moved without a step");
	bypass_path_a: assert property (
		bypass_i |=> y_o == $past(smp_i))
		else $error("bypass not direct");
endmodule // aic_chan

// *** verilog/aic_top.sv ***
// How it works
// - Filter time constant from 3-bit code: 0,2,4,...,64 ms, doubling.
// - Codes 45..51 accepted per input: first all but 48, second only 45, 48, 50; first input starts at 45.
// - General reference use samples each input once per millisecond.
// - First input bipolar 12 bits, second unipolar 10 bits.
// - Code 46 feeds first input, after dead zone and filter stepped each millisecond, out as speed, resampled at 8 kHz.
// - Code 48 scales torque limit 0..100 percent from second input.
// - Torque limit stays in force during emergency and quick stop.
// - Fieldbus may write the torque percentage; that value then wins.
// - Override maps second input onto 0..150 percent, 8-bit result.
// - Sequence variables: first 800..7FF hex, second 0..3FF hex.
// - Override and raw sequence variables work at the same time.
// - Code 51 samples fast torque at 8 or 16 kHz.
// - Fast torque bypasses dead zone and filter.
// - Digital functions may use an analog input as a logic level.
// - Five function selectors, one per standard digital input.
// - Dead zone around zero settable 0..90 percent of full scale.
//
// Design decisions made here: the register addresses and the Wishbone register port.
module aic_top #(
	parameter int unsigned GEN_CYCLES      = aic_pkg::GEN_CYCLES,
	parameter int unsigned SPD_CYCLES      = aic_pkg::SPD_CYCLES,
	parameter int unsigned TRQ_FAST_CYCLES = aic_pkg::TRQ_FAST_CYCLES
) (
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	input  wire logic                  wb_cyc_i,
	input  wire logic                  wb_stb_i,
	input  wire logic                  wb_we_i,
	input  wire logic [7:0]            wb_adr_i,
	input  wire logic [3:0]            wb_sel_i,
	input  wire logic [31:0]           wb_dat_i,
	output logic [31:0]                wb_dat_o,
	output logic                       wb_ack_o,
	input  wire logic signed [11:0]    bipolar_analog_in_i,
	input  wire logic [9:0]            unipolar_analog_in_i,
	output logic signed [11:0]         general_ref_first_o,
	output logic [9:0]                 general_ref_second_o,
	output logic signed [11:0]         speed_ref_o,
	output logic [6:0]                 torque_limit_o,
	output logic signed [11:0]         fast_torque_o,
	output logic [11:0]                first_channel_seq_var_o,
	output logic [9:0]                 second_channel_seq_var_o,
	output logic [7:0]                 speed_factor_display_param_o,
	output logic [7:0]                 speed_factor_var_o,
	output logic [7:0]                 override_pct_o,
	output logic [1:0]                 analog_digital_level_o,
	output aic_pkg::aic_din_sel_t      digital_in_function_sel_o
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		aic_pkg::aic_cfg_t     cfg_first;
		aic_pkg::aic_cfg_t     cfg_second;
		logic [6:0]            fb_pct;
		logic                  fb_en;
		logic                  sf_en;
		logic                  sw16;
		aic_pkg::aic_din_sel_t din_sel;
		logic                  ack;
		logic [31:0]           dat;
		logic signed [11:0]    ref_first;
		logic [9:0]            ref_second;
		logic signed [11:0]    speed_ref;
		logic [6:0]            torque_limit;
		logic signed [11:0]    fast_torque;
		logic [11:0]           seq1;
		logic [9:0]            seq2;
		logic [7:0]            sf_disp;
		logic [7:0]            override_pct;
		logic [1:0]            dig;
	} aic_top_state_t;

	aic_top_state_t     st;
	aic_top_state_t     next_st;
	logic               t_gen;
	logic               t_spd;
	logic               t_trq16;
	logic               t_fast;
	logic signed [11:0] y0;
	logic signed [11:0] y1;
	logic [9:0]         y1u;
	logic [5:0]         f0;
	logic [5:0]         f1;
	logic [6:0]         trq_scaled;
	logic [7:0]         ovr_scaled;
	logic [16:0]        trq_prod;
	logic [17:0]        ovr_prod;
	logic [31:0]        wr_word;
	logic               req;

	// ----------------------------------------------------------------
	// Decoding helpers
	// ----------------------------------------------------------------
	function automatic logic allowed(input logic second, input logic [5:0] code);
		logic ok;
		ok = 1'b0;
		if (code == aic_pkg::FN_OFF) begin
			ok = 1'b1;
		end else if (code >= aic_pkg::FN_DIG_FIRST && code <= aic_pkg::FN_DIG_LAST) begin
			ok = 1'b1;
		end else if (code == aic_pkg::FN_GENERAL || code == aic_pkg::FN_SEQ2) begin
			ok = 1'b1;
		end else if (code == aic_pkg::FN_TSCALE) begin
			ok = second;
		end else if (code == aic_pkg::FN_SPEED || code == aic_pkg::FN_UNUSED47
				|| code == aic_pkg::FN_SEQ1 || code == aic_pkg::FN_FAST_TORQUE) begin
			ok = !second;
		end
		return ok;
	endfunction

	function automatic logic is_digital(input logic [5:0] code);
		return code >= aic_pkg::FN_DIG_FIRST && code <= aic_pkg::FN_DIG_LAST;
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] sel);
		logic [31:0] m;
		m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
		return (old & ~m) | (nw & m);
	endfunction

	function automatic logic [31:0] cfg_pack(input aic_pkg::aic_cfg_t c);
		logic [31:0] w;
		w = 32'h00000000;
		w[aic_pkg::CFG_FUNC_LSB +: 6] = c.func;
		w[aic_pkg::CFG_DZ_LSB +: 7]   = c.dz;
		w[aic_pkg::CFG_FILT_LSB +: 3] = c.filt;
		return w;
	endfunction

	function automatic aic_pkg::aic_cfg_t cfg_unpack(input logic [31:0] w);
		aic_pkg::aic_cfg_t c;
		c.func = w[aic_pkg::CFG_FUNC_LSB +: 6];
		// Out-of-range settings clamp rather than wrap
		c.dz   = (w[aic_pkg::CFG_DZ_LSB +: 7] > aic_pkg::DZ_MAX) ? aic_pkg::DZ_MAX
			: w[aic_pkg::CFG_DZ_LSB +: 7];
		c.filt = (w[aic_pkg::CFG_FILT_LSB +: 3] > aic_pkg::FILT_MAX) ? aic_pkg::FILT_MAX
			: w[aic_pkg::CFG_FILT_LSB +: 3];
		return c;
	endfunction

	function automatic logic [11:0] dz_thr(input logic [6:0] dz, input int sh);
		logic [11:0] p;
		p = 12'(12'(dz) * 12'(aic_pkg::DZ_GAIN));
		return p >> sh;
	endfunction

	// ----------------------------------------------------------------
	// Sample rates and channels
	// ----------------------------------------------------------------
	aic_tick #(.DIV(GEN_CYCLES)) u_tick_gen (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.tick_o (t_gen)
	);
	aic_tick #(.DIV(SPD_CYCLES)) u_tick_spd (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.tick_o (t_spd)
	);
	aic_tick #(.DIV(TRQ_FAST_CYCLES)) u_tick_trq (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.tick_o (t_trq16)
	);

	assign t_fast = st.sw16 ? t_trq16 : t_spd;

	assign f0 = allowed(1'b0, st.cfg_first.func) ? st.cfg_first.func : aic_pkg::FN_OFF;
	assign f1 = allowed(1'b1, st.cfg_second.func) ? st.cfg_second.func : aic_pkg::FN_OFF;

	aic_chan u_chan_first (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.tick_i   (t_gen),
		.bypass_i (f0 == aic_pkg::FN_FAST_TORQUE),
		.filt_i   (st.cfg_first.filt),
		.thr_i    (dz_thr(st.cfg_first.dz, aic_pkg::DZ_SHIFT_FIRST)),
		.smp_i    (bipolar_analog_in_i),
		.y_o      (y0)
	);
	aic_chan u_chan_second (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.tick_i   (t_gen),
		.bypass_i (1'b0),
		.filt_i   (st.cfg_second.filt),
		.thr_i    (dz_thr(st.cfg_second.dz, aic_pkg::DZ_SHIFT_SECOND)),
		.smp_i    ({2'b00, unipolar_analog_in_i}),
		.y_o      (y1)
	);

	assign y1u        = y1[9:0];
	assign trq_prod   = 17'(y1u) * 17'(aic_pkg::TRQ_GAIN);
	assign ovr_prod   = 18'(y1u) * 18'(aic_pkg::OVR_GAIN);
	assign trq_scaled = trq_prod[16:10];
	// Full scale lands on 150 percent
	assign ovr_scaled = ovr_prod[17:10];
	assign req        = wb_cyc_i && wb_stb_i && !st.ack;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		next_st     = st;
		next_st.ack = req;
		wr_word     = 32'h00000000;
		if (req && wb_we_i) begin
			unique case ({wb_adr_i[7:2], 2'b00})
				aic_pkg::REG_CFG_FIRST: begin
					wr_word = merge(cfg_pack(st.cfg_first), wb_dat_i, wb_sel_i);
					next_st.cfg_first = cfg_unpack(wr_word);
				end
				aic_pkg::REG_CFG_SECOND: begin
					wr_word = merge(cfg_pack(st.cfg_second), wb_dat_i, wb_sel_i);
					next_st.cfg_second = cfg_unpack(wr_word);
				end
				aic_pkg::REG_TORQUE_FB: begin
					wr_word = merge({23'h000000, st.fb_en, 1'b0, st.fb_pct}, wb_dat_i, wb_sel_i);
					next_st.fb_pct = wr_word[aic_pkg::FB_PCT_LSB +: 7];
					next_st.fb_en  = wr_word[aic_pkg::FB_EN_BIT];
				end
				aic_pkg::REG_SEQ_CTRL: begin
					wr_word = merge({30'h00000000, st.sw16, st.sf_en}, wb_dat_i, wb_sel_i);
					next_st.sf_en = wr_word[aic_pkg::CTRL_SF_EN_BIT];
					next_st.sw16  = wr_word[aic_pkg::CTRL_SW16_BIT];
				end
				aic_pkg::REG_DIN_SEL: begin
					wr_word = merge({2'b00, st.din_sel}, wb_dat_i, wb_sel_i);
					next_st.din_sel = wr_word[29:0];
				end
				default: begin
					wr_word = 32'h00000000;
				end
			endcase
		end
		if (req && !wb_we_i) begin
			unique case ({wb_adr_i[7:2], 2'b00})
				aic_pkg::REG_CFG_FIRST:  next_st.dat = cfg_pack(st.cfg_first);
				aic_pkg::REG_CFG_SECOND: next_st.dat = cfg_pack(st.cfg_second);
				aic_pkg::REG_TORQUE_FB:  next_st.dat = {23'h000000, st.fb_en, 1'b0, st.fb_pct};
				aic_pkg::REG_SEQ_CTRL:   next_st.dat = {30'h00000000, st.sw16, st.sf_en};
				aic_pkg::REG_DIN_SEL:    next_st.dat = {2'b00, st.din_sel};
				aic_pkg::REG_SEQ_VARS:   next_st.dat = {6'h00, st.seq2, 4'h0, st.seq1};
				aic_pkg::REG_STATUS: begin
					next_st.dat = {st.sf_disp, st.override_pct, 6'h00, st.dig, 1'b0,
						st.torque_limit};
				end
				aic_pkg::REG_REFS: begin
					next_st.dat = {6'h00, st.ref_second, 4'h0, st.ref_first};
				end
				default: next_st.dat = 32'h00000000;
			endcase
		end

		if (f0 != aic_pkg::FN_GENERAL) begin
			next_st.ref_first = 12'sh000;
		end else if (t_gen) begin
			next_st.ref_first = y0;
		end
		if (f1 != aic_pkg::FN_GENERAL) begin
			next_st.ref_second = 10'h000;
		end else if (t_gen) begin
			next_st.ref_second = y1u;
		end

		if (f0 != aic_pkg::FN_SPEED) begin
			next_st.speed_ref = 12'sh000;
		end else if (t_spd) begin
			next_st.speed_ref = y0;
		end

		// No stop input gates the limit
		if (st.fb_en) begin
			next_st.torque_limit = (st.fb_pct > aic_pkg::PCT_FULL) ? aic_pkg::PCT_FULL
				: st.fb_pct;
		end else if (f1 != aic_pkg::FN_TSCALE) begin
			next_st.torque_limit = aic_pkg::PCT_FULL;
		end else if (t_gen) begin
			next_st.torque_limit = trq_scaled;
		end

		if (f0 != aic_pkg::FN_FAST_TORQUE) begin
			next_st.fast_torque = 12'sh000;
		end else if (t_fast) begin
			next_st.fast_torque = y0;
		end

		if (f0 != aic_pkg::FN_SEQ1) begin
			next_st.seq1 = 12'h000;
		end else if (t_gen) begin
			next_st.seq1 = y0;
		end
		// Raw value and override in parallel
		if (f1 != aic_pkg::FN_SEQ2) begin
			next_st.seq2    = 10'h000;
			next_st.sf_disp = 8'h00;
		end else if (t_gen) begin
			next_st.seq2    = y1u;
			next_st.sf_disp = ovr_scaled;
		end
		next_st.override_pct = st.sf_en ? st.sf_disp : aic_pkg::OVR_NEUTRAL;

		// Analog input as a logic level
		next_st.dig[0] = is_digital(f0) && (y0 >= aic_pkg::DIG_THR_FIRST);
		next_st.dig[1] = is_digital(f1) && (y1 >= aic_pkg::DIG_THR_SECOND);
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st              <= '0;
			st.cfg_first    <= aic_pkg::CFG_FIRST_RST;
			st.cfg_second   <= aic_pkg::CFG_SECOND_RST;
			st.din_sel      <= aic_pkg::DIN_SEL_RST;
			st.torque_limit <= aic_pkg::PCT_FULL;
			st.override_pct <= aic_pkg::OVR_NEUTRAL;
		end else begin
			st <= next_st;
		end
	end

	assign wb_dat_o                     = st.dat;
	assign wb_ack_o                     = st.ack;
	assign general_ref_first_o          = st.ref_first;
	assign general_ref_second_o         = st.ref_second;
	assign speed_ref_o                  = st.speed_ref;
	assign torque_limit_o               = st.torque_limit;
	assign fast_torque_o                = st.fast_torque;
	assign first_channel_seq_var_o      = st.seq1;
	assign second_channel_seq_var_o     = st.seq2;
	assign speed_factor_display_param_o = st.sf_disp;
	assign speed_factor_var_o           = st.sf_disp;
	assign override_pct_o               = st.override_pct;
	assign analog_digital_level_o       = st.dig;
	assign digital_in_function_sel_o    = st.din_sel;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence bus_req_s;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence bus_ack_s;
		wb_ack_o ##1 !wb_ack_o;
	endsequence

	bus_answer_a: assert property (bus_req_s |=> bus_ack_s)
		else $error("bus answer not one cycle");
	func_default_a: assert property ($past(rst_i) |-> st.cfg_first.func == aic_pkg::FN_GENERAL)
		else $error("first input default code wrong");
	gen_sample_a: assert property (f0 == aic_pkg::FN_GENERAL && t_gen |=> general_ref_first_o == $past(y0))
		else $error("general reference not sampled");
	speed_direct_a: assert property (f0 == aic_pkg::FN_SPEED && t_spd |=> speed_ref_o == $past(y0))
		else $error("speed reference not sampled");
	torque_scale_a: assert property (!st.fb_en && f1 == aic_pkg::FN_TSCALE && t_gen ##1 !st.fb_en
		|-> torque_limit_o == $past(trq_scaled))
		else $error("torque scaling wrong");
	torque_bus_a: assert property (st.fb_en && st.fb_pct <= aic_pkg::PCT_FULL
		|=> torque_limit_o == $past(st.fb_pct))
		else $error("fieldbus torque not used");
	override_gate_a: assert property (!st.sf_en |=> override_pct_o == aic_pkg::OVR_NEUTRAL)
		else $error("override active while disabled");
	seq_vars_a: assert property (f1 == aic_pkg::FN_SEQ2 && t_gen
		|=> second_channel_seq_var_o == $past(y1u) && speed_factor_var_o == $past(ovr_scaled))
		else $error("sequence variable or override lost");
	seq_first_a: assert property (f0 == aic_pkg::FN_SEQ1 && t_gen |=> first_channel_seq_var_o == $past(y0))
		else $error("first sequence variable wrong");
	fast_torque_a: assert property (f0 == aic_pkg::FN_FAST_TORQUE && t_fast
		|=> fast_torque_o == $past(y0))
		else $error("fast torque not sampled");
	bad_code_a: assert property (st.cfg_second.func == aic_pkg::FN_SPEED
		|=> general_ref_second_o == 10'h000 && analog_digital_level_o[1] == 1'b0)
		else $error("illegal code took effect");
	dig_level_a: assert property (is_digital(f0) && y0 >= aic_pkg::DIG_THR_FIRST
		|=> analog_digital_level_o[0])
		else $error("digital level missing");
endmodule // aic_top

// *** tb/aic_far_model.sv ***
// ----------------------------------------------------------------
// Analog front end
// ----------------------------------------------------------------
module aic_far_model (
	input  wire logic               clk_i,
	input  wire logic signed [11:0] bip_set_i,
	input  wire logic [9:0]         uni_set_i,
	output logic signed [11:0]      bip_o,
	output logic [9:0]              uni_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// Converter widths
	// One register stage, as a converter result would lag
	always_ff @(posedge clk_i) begin
		bip_o <= bip_set_i;
		uni_o <= uni_set_i;
	end
endmodule // aic_far_model

// *** tb/analog_input_conditioning_tb_top.sv ***
module analog_input_conditioning_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {logic [15:0] cfg; logic [11:0] s; logic [3:0] m;} aic_row_t;
	logic clk, rst, cyc, stb, we, ack;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, rdat, q;
	logic signed [11:0] bip_set, bip, gen1, spd, fast;
	logic [9:0] uni_set, uni, gen2, seq2;
	logic [11:0] seq1;
	logic [7:0] sfd, sfv, ovr;
	logic [6:0] trq;
	logic [1:0] dig;
	aic_pkg::aic_din_sel_t dsel;
	int miscompares = 0;
	int n_checks = 0;
	aic_row_t rows[8] = '{'{16'h002d, 12'h9ab, 4'h1}, '{16'h002e, 12'h7ff, 4'h2},
		'{16'h0033, 12'h800, 4'h4}, '{16'h0031, 12'h123, 4'h8}, '{16'h0030, 12'h555, 4'h0},
		'{16'h002f, 12'h321, 4'h0}, '{16'h0a2d, 12'h064, 4'h0}, '{16'h0a33, 12'h064, 4'h4}};
	// Row 6 sits inside the dead band, row 7 must skip it
	aic_top #(.GEN_CYCLES(40), .SPD_CYCLES(8), .TRQ_FAST_CYCLES(4)) dut_u (.clk_i(clk),
		.rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.bipolar_analog_in_i(bip), .unipolar_analog_in_i(uni), .general_ref_first_o(gen1),
		.general_ref_second_o(gen2), .speed_ref_o(spd), .torque_limit_o(trq),
		.fast_torque_o(fast), .first_channel_seq_var_o(seq1), .second_channel_seq_var_o(seq2),
		.speed_factor_display_param_o(sfd), .speed_factor_var_o(sfv), .override_pct_o(ovr),
		.analog_digital_level_o(dig), .digital_in_function_sel_o(dsel));
	aic_far_model far_u (.clk_i(clk), .bip_set_i(bip_set), .uni_set_i(uni_set), .bip_o(bip),
		.uni_o(uni));
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic wrap_up();
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// Bounded wait for ack; a lost ack ends the run
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (n >= 50) begin
			miscompares++;
			wrap_up();
		end
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask
	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		rst = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; sel = 4'hf;
		wdat = 32'h0; bip_set = 12'sh000; uni_set = 10'h000;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk(trq, 12'h064);
		chk(ovr, 12'h064);
		chk(dsel[0], 12'h001);
		wb(1'b0, 8'h00, 32'h0);
		chk(q[5:0], 12'h02d);
		wb(1'b0, 8'h20, 32'h0);
		chk(q[11:0], 12'h000);
		$display("test reset done");
		// Ordinary first-input codes; 100 cycles covers two general ticks and every faster rate
		for (int i = 0; i < 8; i++) begin
			wb(1'b1, 8'h00, {16'h0, rows[i].cfg});
			bip_set <= rows[i].s;
			repeat (100) @(posedge clk);
			chk(gen1, rows[i].m[0] ? rows[i].s : 12'h000);
			chk(spd, rows[i].m[1] ? rows[i].s : 12'h000);
			chk(fast, rows[i].m[2] ? rows[i].s : 12'h000);
			chk(seq1, rows[i].m[3] ? rows[i].s : 12'h000);
			$display("test row %0d done", i);
		end
		// Override with raw variable running beside it
		wb(1'b1, 8'h00, 32'h31);
		wb(1'b1, 8'h04, 32'h32);
		bip_set <= 12'sh456;
		uni_set <= 10'h3ff;
		repeat (100) @(posedge clk);
		chk(seq2, 12'h3ff);
		chk(seq1, 12'h456);
		chk(sfv, 12'h096);
		chk(sfd, 12'h096);
		chk(ovr, 12'h064);
		wb(1'b1, 8'h0c, 32'h1);
		repeat (3) @(posedge clk);
		chk(ovr, 12'h096);
		$display("test override done");
		// Torque scaling, then the fieldbus figure takes over
		wb(1'b1, 8'h04, 32'h30);
		uni_set <= 10'h200;
		repeat (100) @(posedge clk);
		chk(trq, 12'h032);
		wb(1'b1, 8'h08, 32'h108);
		repeat (3) @(posedge clk);
		chk(trq, 12'h008);
		$display("test torque done");
		// Second input general use, then illegal code; first input as a level
		wb(1'b1, 8'h08, 32'h0);
		wb(1'b1, 8'h04, 32'h2d);
		repeat (100) @(posedge clk);
		chk(gen2, 12'h200);
		wb(1'b1, 8'h04, 32'h2e);
		wb(1'b1, 8'h00, 32'h01);
		bip_set <= 12'sh500;
		repeat (100) @(posedge clk);
		chk(gen2, 12'h000);
		chk(dig, 12'h001);
		$display("test codes done");
		wrap_up();
	end
endmodule // analog_input_conditioning_tb_top
